/* rtl/cfgp_defs.vh */
`ifndef CFGP_DEFS_VH
`define CFGP_DEFS_VH

// Register byte offsets
`define CFGP_REG_CTRL 4'h0
`define CFGP_REG_CMD 4'h1
`define CFGP_REG_TIMING 4'h2
`define CFGP_REG_STATUS 4'h3
`define CFGP_REG_MODE 4'h4
`define CFGP_REG_FADDR 4'h5
`define CFGP_REG_FDATA 4'h6

// CTRL fields
`define CFGP_CTRL_RB_EN 0
`define CFGP_CTRL_TS_AFTER 1
`define CFGP_CTRL_GSR_ROLE 2
`define CFGP_CTRL_CHAIN_LEAD 3
`define CFGP_CTRL_RST 4'h0

// CMD fields
`define CFGP_CMD_LOAD_DONE 0
`define CFGP_CMD_RESTART 1

// TIMING fields and reset
`define CFGP_TIM_DONE_LSB 0
`define CFGP_TIM_IO_LSB 4
`define CFGP_TIM_RST 8'h11

// Mode-select encodings
`define CFGP_MODE_SLAVE_SER 4'h0
`define CFGP_MODE_MASTER_SER 4'h1
`define CFGP_MODE_ASYNC_PER 4'h2
`define CFGP_MODE_MASTER_PAR 4'h3
`define CFGP_MODE_SYNC_PER 4'h4
`define CFGP_MODE_SYSBUS 4'h5
`define CFGP_MODE_SLAVE_PAR 4'h6
`define CFGP_MODE_JTAG 4'h7

// States
`define CFGP_ST_INIT 3'h0
`define CFGP_ST_CFG 3'h1
`define CFGP_ST_START 3'h2
`define CFGP_ST_REL 3'h3
`define CFGP_ST_USER 3'h4

// Timing
`define CFGP_CLK_NS 8
`define CFGP_INIT_NS 256
`define CFGP_INIT_CYC ((`CFGP_INIT_NS + `CFGP_CLK_NS - 1) / `CFGP_CLK_NS)
`define CFGP_CONFIG_CLOCK_DIV 8'h04

// Readback frame store
`define CFGP_FRAMES 16
`define CFGP_FIDX_W 5

`endif

/* rtl/cfgp_sync.v */
`timescale 1ns/10ps
module cfgp_sync #(
  parameter W = 1,
  parameter [W-1:0] RV = {W{1'b1}}
) (
  input wire clk, // Sampling clock
  input wire rst_n, // Async reset, active low
  input wire [W-1:0] d, // Asynchronous inputs
  output reg [W-1:0] q // Synchronised copy
);
  reg [W-1:0] meta_r;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= RV;
      q <= RV;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule // cfgp_sync

/* rtl/cfgp_top.v */
`timescale 1ns/10ps
`include "cfgp_defs.vh"
module cfgp_top (
  input wire CLK, // System clock, 125 MHz
  input wire RST_N, // Async reset, active low
  input wire RESET_PIN_N, // Reset pin, active low
  input wire PROGRAM_RESTART_N, // Program pin, active low
  input wire READBACK_CTL_N, // Readback control pin
  input wire [3:0] MODE_SEL, // Mode select pins
  input wire CONFIG_CLOCK_I, // Config clock pin level
  output reg CONFIG_CLOCK_O, // Config clock drive value
  output reg CONFIG_CLOCK_OE_N, // Config clock enable, low drives
  input wire DONE_I, // Completion pin level
  output wire DONE_O, // Completion pin drive value
  output reg DONE_OE_N, // Completion pin enable, low drives
  output reg CFG_IRQ_N, // Config or host port interrupt
  input wire HOST_PORT_IRQ_N, // Host port interrupt request
  input wire RAM_INIT_ERR, // RAM or core init error pulse
  input wire [7:0] LU_STATE, // Logic unit output states
  input wire TDO_SEL, // Boundary scan owns shared pin
  input wire TDO_IN, // Boundary scan test data
  output reg RD_DATA_TDO, // Shared readback or test data out
  output reg BSCAN_RST, // Boundary scan reset
  output reg IO_HIZ, // User I/O high impedance
  output reg IO_PULLUP, // User I/O pull-up enable
  output wire UNUSED_HIZ, // Unused pin high impedance
  output wire UNUSED_PULLUP, // Unused pin pull-up enable
  output reg RESET_PU, // Reset pin pull-up enable
  output wire PROGRAM_PU, // Program pin pull-up enable
  output wire READBACK_PU, // Readback control pull-up enable
  output reg MODE_PU, // Mode pin pull-up enable
  output reg GLOBAL_TRISTATE, // Global tristate active
  output reg GSR_OUT, // Global set/reset to logic cells
  output reg RESET_USER_N, // Reset pin as general input
  output reg BUSY_HIGH_FLAG, // High while configuring
  output reg BUSY_LOW_FLAG_N, // Low while configuring
  input wire [3:0] ADDR, // Register address
  input wire [7:0] WDATA, // Register write data
  input wire WR, // Write strobe
  input wire RD, // Read strobe
  output reg [7:0] RDATA // Read data, cycle after RD
);
  reg rst_m_r;
  reg rst_s_r;
  wire rst_n;
  wire [8:0] pins_s;
  wire reset_s;
  wire program_restart_n_s;
  wire rdcfg_s;
  wire done_s;
  wire config_clock_s;
  wire [3:0] mode_s;
  reg rdcfg_d_r;
  reg config_clock_d_r;
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [8:0] cnt_r;
  reg [8:0] cnt_nxt;
  reg [3:0] mode_r;
  reg [3:0] ctrl_r;
  reg [7:0] tim_r;
  reg err_r;
  reg load_done_r;
  reg [3:0] faddr_r;
  reg [7:0] frame_mem [0:`CFGP_FRAMES-1];
  reg [7:0] div_r;
  reg config_clock_r;
  reg rb_act_r;
  reg [`CFGP_FIDX_W-1:0] rb_idx_r;
  reg [2:0] rb_bit_r;
  reg [7:0] lu_cap_r;
  reg rb_data_r;
  wire in_cfg;
  wire restart;
  wire wr_cmd;
  wire rd_fall;
  wire config_clock_rise;
  wire drive_config_clock;
  wire irq_mode;
  wire gts;
  wire [7:0] rb_byte;
  wire [3:0] done_dly;
  wire [3:0] io_dly;

  // Reset release through two flops
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_m_r <= 1'b0;
      rst_s_r <= 1'b0;
    end else begin
      rst_m_r <= 1'b1;
      rst_s_r <= rst_m_r;
    end
  end
  assign rst_n = rst_s_r;

  // Synced pins reset high, the idle level of the pulled-up pins; the config clock pin has no pull-up
  cfgp_sync #(.W(9), .RV(9'h1ff)) u_sync (
    .clk(CLK),
    .rst_n(rst_n),
    .d({RESET_PIN_N, PROGRAM_RESTART_N, READBACK_CTL_N, DONE_I, CONFIG_CLOCK_I, MODE_SEL}),
    .q(pins_s)
  );
  assign reset_s = pins_s[8];
  assign program_restart_n_s = pins_s[7];
  assign rdcfg_s = pins_s[6];
  assign done_s = pins_s[5];
  assign config_clock_s = pins_s[4];
  assign mode_s = pins_s[3:0];

  assign in_cfg = (state_r != `CFGP_ST_USER);
  assign done_dly = tim_r[`CFGP_TIM_DONE_LSB +: 4];
  assign io_dly = tim_r[`CFGP_TIM_IO_LSB +: 4];
  assign wr_cmd = WR && (ADDR == `CFGP_REG_CMD);
  assign restart = (in_cfg && !reset_s) || !program_restart_n_s ||
    (wr_cmd && WDATA[`CFGP_CMD_RESTART]);
  assign rd_fall = rdcfg_d_r && !rdcfg_s;
  assign config_clock_rise = !config_clock_d_r && config_clock_s;

  // Main sequence
  always @* begin
    state_nxt = state_r;
    cnt_nxt = cnt_r + 9'h001;
    case (state_r)
      `CFGP_ST_INIT: begin
        if (cnt_r == `CFGP_INIT_CYC - 1) begin
          state_nxt = `CFGP_ST_CFG;
          cnt_nxt = 9'h000;
        end
      end
      `CFGP_ST_CFG: begin
        cnt_nxt = 9'h000;
        if (load_done_r)
          state_nxt = `CFGP_ST_START;
      end
      `CFGP_ST_START: begin
        if (cnt_r[3:0] == done_dly) begin
          state_nxt = `CFGP_ST_REL;
          cnt_nxt = 9'h000;
        end
      end
      `CFGP_ST_REL: begin
        if (!done_s)
          cnt_nxt = 9'h000;
        else if (cnt_r[3:0] == io_dly)
          state_nxt = `CFGP_ST_USER;
      end
      `CFGP_ST_USER: begin
        cnt_nxt = 9'h000;
      end
      default: begin
        state_nxt = `CFGP_ST_INIT;
        cnt_nxt = 9'h000;
      end
    endcase
    if (restart) begin
      state_nxt = `CFGP_ST_INIT;
      cnt_nxt = 9'h000;
    end
  end

  always @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= `CFGP_ST_INIT;
      cnt_r <= 9'h000;
      mode_r <= `CFGP_MODE_SLAVE_SER;
      rdcfg_d_r <= 1'b1;
      config_clock_d_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      rdcfg_d_r <= rdcfg_s;
      config_clock_d_r <= config_clock_s;
      // Mode pins latched as the sequence leaves its init phase
      if (state_r == `CFGP_ST_INIT && state_nxt == `CFGP_ST_CFG)
        mode_r <= mode_s;
    end
  end

  // Registers
  always @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= `CFGP_CTRL_RST;
      tim_r <= `CFGP_TIM_RST;
      load_done_r <= 1'b0;
      err_r <= 1'b0;
      faddr_r <= 4'h0;
      RDATA <= 8'h00;
    end else begin
      if (WR && ADDR == `CFGP_REG_CTRL)
        ctrl_r <= WDATA[3:0];
      if (WR && ADDR == `CFGP_REG_TIMING)
        tim_r <= WDATA;
      if (WR && ADDR == `CFGP_REG_FADDR)
        faddr_r <= WDATA[3:0];
      else if (WR && ADDR == `CFGP_REG_FDATA)
        faddr_r <= faddr_r + 4'h1;
      if (restart || state_r != `CFGP_ST_CFG)
        load_done_r <= 1'b0;
      else if (wr_cmd && WDATA[`CFGP_CMD_LOAD_DONE])
        load_done_r <= 1'b1;
      // Error set wins over a restart clear in the same cycle
      if (RAM_INIT_ERR && in_cfg)
        err_r <= 1'b1;
      else if (restart)
        err_r <= 1'b0;
      RDATA <= 8'h00;
      if (RD) begin
        case (ADDR)
          `CFGP_REG_CTRL: RDATA <= {4'h0, ctrl_r};
          `CFGP_REG_TIMING: RDATA <= tim_r;
          `CFGP_REG_STATUS: RDATA <= {2'b00, done_s, rb_act_r, err_r, state_r};
          `CFGP_REG_MODE: RDATA <= {4'h0, mode_r};
          `CFGP_REG_FADDR: RDATA <= {4'h0, faddr_r};
          default: RDATA <= 8'h00;
        endcase
      end
    end
  end

  // Frame store has no reset; software fills it before readback
  always @(posedge CLK) begin
    if (WR && ADDR == `CFGP_REG_FDATA)
      frame_mem[faddr_r] <= WDATA;
  end

  // Config clock direction per mode
  assign drive_config_clock = in_cfg && state_r != `CFGP_ST_INIT &&
    ((mode_r == `CFGP_MODE_MASTER_SER) || (mode_r == `CFGP_MODE_MASTER_PAR) ||
     (mode_r == `CFGP_MODE_ASYNC_PER) ||
     (ctrl_r[`CFGP_CTRL_CHAIN_LEAD] &&
      ((mode_r == `CFGP_MODE_SYNC_PER) || (mode_r == `CFGP_MODE_SYSBUS))));

  always @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= 8'h00;
      config_clock_r <= 1'b0;
      CONFIG_CLOCK_O <= 1'b0;
      CONFIG_CLOCK_OE_N <= 1'b1;
    end else begin
      if (!drive_config_clock) begin
        div_r <= 8'h00;
        config_clock_r <= 1'b0;
      end else if (div_r == `CFGP_CONFIG_CLOCK_DIV - 8'h01) begin
        div_r <= 8'h00;
        config_clock_r <= !config_clock_r;
      end else begin
        div_r <= div_r + 8'h01;
      end
      CONFIG_CLOCK_O <= config_clock_r;
      // Slave and readback take the clock from outside
      CONFIG_CLOCK_OE_N <= !drive_config_clock;
    end
  end

  // Readback: frames in order, then captured logic unit states
  assign rb_byte = (rb_idx_r == `CFGP_FRAMES) ? lu_cap_r : frame_mem[rb_idx_r[3:0]];

  always @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      rb_act_r <= 1'b0;
      rb_idx_r <= {`CFGP_FIDX_W{1'b0}};
      rb_bit_r <= 3'h0;
      lu_cap_r <= 8'h00;
      rb_data_r <= 1'b0;
    end else if (!in_cfg && !rb_act_r) begin
      if (ctrl_r[`CFGP_CTRL_RB_EN] && rd_fall) begin
        rb_act_r <= 1'b1;
        rb_idx_r <= {`CFGP_FIDX_W{1'b0}};
        rb_bit_r <= 3'h0;
        lu_cap_r <= LU_STATE;
      end
    end else if (rb_act_r && in_cfg) begin
      rb_act_r <= 1'b0;
    end else if (rb_act_r && config_clock_rise) begin
      rb_data_r <= rb_byte[3'h7 - rb_bit_r];
      rb_bit_r <= rb_bit_r + 3'h1;
      if (rb_bit_r == 3'h7) begin
        rb_idx_r <= rb_idx_r + {{(`CFGP_FIDX_W-1){1'b0}}, 1'b1};
        if (rb_idx_r == `CFGP_FRAMES)
          rb_act_r <= 1'b0;
      end
    end
  end

  // Pin and flag outputs
  assign irq_mode = (mode_r == `CFGP_MODE_JTAG) || (mode_r == `CFGP_MODE_SLAVE_SER) ||
    (mode_r == `CFGP_MODE_SLAVE_PAR) || (mode_r == `CFGP_MODE_MASTER_SER) ||
    (mode_r == `CFGP_MODE_MASTER_PAR) || (mode_r == `CFGP_MODE_ASYNC_PER);
  // Readback control ignored in init, where the host holds it high
  assign gts = (in_cfg && state_r != `CFGP_ST_INIT && !rdcfg_s) ||
    (!in_cfg && ctrl_r[`CFGP_CTRL_TS_AFTER] && !rdcfg_s);

  assign DONE_O = 1'b0;
  assign UNUSED_HIZ = 1'b1;
  assign UNUSED_PULLUP = 1'b1;
  assign PROGRAM_PU = 1'b1;
  assign READBACK_PU = 1'b1;

  always @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      DONE_OE_N <= 1'b0;
      CFG_IRQ_N <= 1'b1;
      RD_DATA_TDO <= 1'b0;
      BSCAN_RST <= 1'b1;
      IO_HIZ <= 1'b1;
      IO_PULLUP <= 1'b1;
      RESET_PU <= 1'b1;
      MODE_PU <= 1'b1;
      GLOBAL_TRISTATE <= 1'b0;
      GSR_OUT <= 1'b0;
      RESET_USER_N <= 1'b1;
      BUSY_HIGH_FLAG <= 1'b1;
      BUSY_LOW_FLAG_N <= 1'b0;
    end else begin
      // Pulled low until the completion delay expires
      DONE_OE_N <= (state_r == `CFGP_ST_REL) || !in_cfg;
      CFG_IRQ_N <= in_cfg ? !(err_r && irq_mode) : HOST_PORT_IRQ_N;
      RD_DATA_TDO <= TDO_SEL ? TDO_IN : rb_data_r;
      BSCAN_RST <= !program_restart_n_s;
      IO_HIZ <= in_cfg || gts;
      IO_PULLUP <= in_cfg;
      RESET_PU <= in_cfg;
      MODE_PU <= in_cfg;
      GLOBAL_TRISTATE <= gts;
      GSR_OUT <= !in_cfg && ctrl_r[`CFGP_CTRL_GSR_ROLE] && !reset_s;
      RESET_USER_N <= (in_cfg || ctrl_r[`CFGP_CTRL_GSR_ROLE]) ? 1'b1 : reset_s;
      BUSY_HIGH_FLAG <= in_cfg;
      BUSY_LOW_FLAG_N <= !in_cfg;
    end
  end
endmodule // cfgp_top

/* test/cfgp_monitor.sv */
`timescale 1ns/10ps
module cfgp_monitor (
  input CLK, // Clock
  input RST_N, // Reset
  input PROGRAM_RESTART_N, // Pin
  input DONE_O, // Pin
  input DONE_OE_N, // Pin
  input BUSY_HIGH_FLAG, // Flag
  input BUSY_LOW_FLAG_N, // Flag
  input IO_HIZ, // I/O
  input IO_PULLUP, // I/O
  input RESET_PU, // Pull-up
  input MODE_PU, // Pull-up
  input UNUSED_HIZ, // Pin
  input UNUSED_PULLUP, // Pin
  input PROGRAM_PU, // Pull-up
  input READBACK_PU, // Pull-up
  input BSCAN_RST, // Scan
  input CONFIG_CLOCK_OE_N, // Clock pin
  input CFG_IRQ_N, // Irq
  input HOST_PORT_IRQ_N, // Irq
  input TDO_SEL, // Scan
  input TDO_IN, // Scan
  input RD_DATA_TDO // Shared pin
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // Three lows fill the two-flop sync and the output register
  sequence prog_low;
    !PROGRAM_RESTART_N [*3];
  endsequence
  // Two samples so a restart out of user mode is not misread
  sequence user_2;
    !BUSY_HIGH_FLAG ##1 !BUSY_HIGH_FLAG;
  endsequence
  unused_pins_a: assert property (UNUSED_HIZ && UNUSED_PULLUP)
    else $error("unused pin not floated");
  pin_pullups_a: assert property (PROGRAM_PU && READBACK_PU)
    else $error("control pull-up off");
  busy_pair_a: assert property (BUSY_HIGH_FLAG != BUSY_LOW_FLAG_N)
    else $error("busy flags disagree");
  cfg_float_a: assert property (BUSY_HIGH_FLAG |-> IO_HIZ && IO_PULLUP && RESET_PU && MODE_PU)
    else $error("pins not floated while configuring");
  done_drain_a: assert property (DONE_O == 1'b0)
    else $error("completion pin not open drain");
  done_first_a: assert property ($fell(BUSY_HIGH_FLAG) |-> DONE_OE_N)
    else $error("user mode before completion release");
  scan_reset_a: assert property (prog_low |=> BSCAN_RST)
    else $error("scan reset missing");
  prog_restart_a: assert property (prog_low ##1 !PROGRAM_RESTART_N [*2] |=> BUSY_HIGH_FLAG)
    else $error("program pin did not restart");
  user_clock_a: assert property (user_2 |-> CONFIG_CLOCK_OE_N)
    else $error("config clock driven in user mode");
  irq_follow_a: assert property (user_2 |-> CFG_IRQ_N == $past(HOST_PORT_IRQ_N))
    else $error("host irq not passed");
  tdo_pass_a: assert property (TDO_SEL && $past(TDO_SEL) |-> RD_DATA_TDO == $past(TDO_IN))
    else $error("test data not passed");
endmodule // cfgp_monitor
bind cfgp_top cfgp_monitor cfgp_monitor_i (.CLK, .RST_N, .PROGRAM_RESTART_N, .DONE_O,
  .DONE_OE_N, .BUSY_HIGH_FLAG, .BUSY_LOW_FLAG_N, .IO_HIZ, .IO_PULLUP, .RESET_PU, .MODE_PU,
  .UNUSED_HIZ, .UNUSED_PULLUP, .PROGRAM_PU, .READBACK_PU, .BSCAN_RST, .CONFIG_CLOCK_OE_N,
  .CFG_IRQ_N, .HOST_PORT_IRQ_N, .TDO_SEL, .TDO_IN, .RD_DATA_TDO);

/* test/cfgp_cfg_src.sv */
`timescale 1ns/10ps
module cfgp_cfg_src (
  input run, // Run external clock
  input hold, // Hold completion low
  input config_clock_o, // Device clock value
  input config_clock_oe_n, // Device clock enable
  input done_o, // Device done value
  input done_oe_n, // Device done enable
  output config_clock, // Clock wire
  output done // Completion wire
);
  logic ext = 1'b0;
  // Clock stands still at 0 between readbacks
  always @(posedge run) begin
    while (run) begin
      // Run dropped at the last fall gives no stray rise
      #62.5 ext = run;
      #62.5 ext = 1'b0;
    end
  end
  assign config_clock = config_clock_oe_n ? ext : config_clock_o;
  // Pull-up wins unless someone sinks the line
  assign done = ((!done_oe_n && !done_o) || hold) ? 1'b0 : 1'b1;
endmodule // cfgp_cfg_src

/* test/tb.sv */
`timescale 1ns/10ps
module tb;
  logic clk = 0, rst_n = 0, rstp = 1, prg = 1, rbn = 1, hirq = 1, err = 0, tsel = 0, tin = 0;
  logic wr = 0, rd = 0, run = 0, hold = 0;
  logic [3:0] mode = 4'h1, addr = 4'h0;
  logic [7:0] wdata = 8'h00, lu = 8'h00, rdata, b;
  wire config_clock, done, co, coe_n, d_o, doe_n, irq_n, tdo, bsr, hiz, pu, gt, gsr, rusr, bh, bl_n;
  int miscompares = 0, num_checks = 0;
  realtime t;
  always #4 clk = ~clk;
  cfgp_top cfgp_top_i (.CLK(clk), .RST_N(rst_n), .RESET_PIN_N(rstp), .PROGRAM_RESTART_N(prg),
    .READBACK_CTL_N(rbn), .MODE_SEL(mode), .CONFIG_CLOCK_I(config_clock), .CONFIG_CLOCK_O(co),
    .CONFIG_CLOCK_OE_N(coe_n), .DONE_I(done), .DONE_O(d_o), .DONE_OE_N(doe_n),
    .CFG_IRQ_N(irq_n), .HOST_PORT_IRQ_N(hirq), .RAM_INIT_ERR(err), .LU_STATE(lu),
    .TDO_SEL(tsel), .TDO_IN(tin), .RD_DATA_TDO(tdo), .BSCAN_RST(bsr), .IO_HIZ(hiz),
    .IO_PULLUP(pu), .UNUSED_HIZ(), .UNUSED_PULLUP(), .RESET_PU(), .PROGRAM_PU(),
    .READBACK_PU(), .MODE_PU(), .GLOBAL_TRISTATE(gt), .GSR_OUT(gsr), .RESET_USER_N(rusr),
    .BUSY_HIGH_FLAG(bh), .BUSY_LOW_FLAG_N(bl_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata));
  cfgp_cfg_src cfgp_cfg_src_i (.run(run), .hold(hold), .config_clock_o(co), .config_clock_oe_n(coe_n),
    .done_o(d_o), .done_oe_n(doe_n), .config_clock(config_clock), .done(done));
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic w(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1;
    @(posedge clk);
    wr <= 0;
  endtask
  task automatic r(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1;
    @(posedge clk);
    rd <= 0;
    #1 chk("rdata", rdata, e);
  endtask
  // Ends just past an edge so outputs have settled
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic stop_test;
    if (miscompares == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    #100000;
    miscompares++;
    stop_test;
  end
  initial begin
    cyc(10);
    rst_n <= 1;
    cyc(40);
    r(4'h3, 8'h01);
    r(4'h4, 8'h01);
    r(4'h2, 8'h11);
    r(4'h0, 8'h00);
    r(4'hf, 8'h00);
    chk("clk_oe_n", coe_n, 0);
    chk("io_hiz", hiz, 1);
    rbn <= 0;
    cyc(5);
    chk("tristate", gt, 1);
    rbn <= 1;
    err <= 1;
    cyc(1);
    err <= 0;
    cyc(2);
    chk("cfg_irq_n", irq_n, 0);
    r(4'h3, 8'h09);
    rstp <= 0;
    cyc(5);
    rstp <= 1;
    r(4'h3, 8'h00);
    cyc(40);
    r(4'h3, 8'h01);
    w(4'h5, 8'h00);
    for (int i = 0; i < 16; i++) w(4'h6, {i[3:0], ~i[3:0]});
    w(4'h0, 8'h01);
    hold <= 1;
    w(4'h1, 8'h01);
    cyc(20);
    r(4'h3, 8'h03);
    chk("done_oe_n", doe_n, 1);
    chk("busy_high", bh, 1);
    hold <= 0;
    for (int i = 0; i < 200 && bh !== 1'b0; i++) cyc(1);
    chk("busy_high", bh, 0);
    chk("busy_low_n", bl_n, 1);
    chk("io_hiz", hiz, 0);
    chk("io_pullup", pu, 0);
    r(4'h3, 8'h24);
    rstp <= 0;
    cyc(5);
    chk("reset_user_n", rusr, 0);
    chk("busy_high", bh, 0);
    w(4'h0, 8'h05);
    cyc(4);
    chk("gsr", gsr, 1);
    rstp <= 1;
    w(4'h0, 8'h01);
    hirq <= 0;
    cyc(3);
    chk("cfg_irq_n", irq_n, 0);
    hirq <= 1;
    lu <= 8'ha5;
    run <= 1;
    rbn <= 0;
    // One bit per external clock, sampled 1 ns after each fall
    for (int n = 0; n < 136; n++) begin
      @(negedge config_clock);
      #1;
      b = (n < 128) ? {n[6:3], ~n[6:3]} : 8'ha5;
      chk("rb_bit", tdo, b[7 - n % 8]);
    end
    run <= 0;
    chk("tristate", gt, 0);
    r(4'h3, 8'h24);
    w(4'h0, 8'h03);
    cyc(5);
    chk("tristate", gt, 1);
    rbn <= 1;
    tsel <= 1;
    tin <= 1;
    cyc(3);
    chk("tdo", tdo, 1);
    tin <= 0;
    cyc(2);
    chk("tdo", tdo, 0);
    tsel <= 0;
    prg <= 0;
    cyc(6);
    chk("bscan_rst", bsr, 1);
    r(4'h3, 8'h00);
    prg <= 1;
    cyc(5);
    chk("busy_high", bh, 1);
    // Sync peripheral: clock only as chain lead, no error interrupt
    mode <= 4'h4;
    cyc(40);
    r(4'h4, 8'h04);
    chk("clk_oe_n", coe_n, 1);
    w(4'h0, 8'h08);
    cyc(3);
    chk("clk_oe_n", coe_n, 0);
    @(posedge config_clock);
    t = $realtime;
    @(posedge config_clock);
    chk("config_clock_period", $rtoi($realtime - t), 8'h40);
    err <= 1;
    cyc(1);
    err <= 0;
    cyc(2);
    chk("cfg_irq_n", irq_n, 1);
    r(4'h3, 8'h09);
    stop_test;
  end
endmodule // tb
